// ===== csp_pkg.sv
`default_nettype none

package csp_pkg;

  // ---------------------------------------------------------------
  // Fuse codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CSP_SRCSEL_EXT   = 4'h0;
  localparam logic [3:0] CSP_SRCSEL_RC    = 4'h2;
  localparam logic [3:0] CSP_SRCSEL_LFX_F = 4'h6;
  localparam logic [3:0] CSP_SRCSEL_LFX_S = 4'h7;
  localparam logic [1:0] CSP_DLY_14CK     = 2'h0;
  localparam logic [1:0] CSP_DLY_SHORT    = 2'h1;
  localparam logic [1:0] CSP_DLY_LONG     = 2'h2;
  localparam logic [1:0] CSP_DLY_RSVD     = 2'h3;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam int unsigned CSP_CLK_HZ      = 50_000_000;
  localparam int          CSP_CNT_W       = 17;
  localparam logic [16:0] CSP_RST_CK      = 17'h0_000E;
  localparam logic [16:0] CSP_WAKE_RC_CK  = 17'h0_0006;
  localparam logic [16:0] CSP_WAKE_1K_CK  = 17'h0_0400;
  localparam logic [16:0] CSP_FUSE_SETTLE = 17'h0_0003;
  localparam logic [2:0]  CSP_PCE_WINDOW  = 3'h4;

  // ---------------------------------------------------------------
  // Prescaler codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CSP_PS_DIV1   = 4'h0;
  localparam logic [3:0] CSP_PS_DIV8   = 4'h3;
  localparam logic [3:0] CSP_PS_MAX    = 4'h8;

  // ---------------------------------------------------------------
  // Register map (word index, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam int         CSP_AW          = 5;
  localparam logic [2:0] CSP_IDX_TRIM    = 3'h0;
  localparam logic [2:0] CSP_IDX_PRESC   = 3'h1;
  localparam logic [2:0] CSP_IDX_ASYNC   = 3'h2;
  localparam logic [2:0] CSP_IDX_STATUS  = 3'h3;
  localparam int         CSP_PCE_BIT     = 7;
  localparam int         CSP_TOSC_EN_BIT = 0;
  localparam int         CSP_TOSC_EXT_BIT= 1;
  localparam logic [7:0] CSP_PCE_ONLY    = 8'h80;
  localparam logic [7:0] CSP_TRIM_RST    = 8'h80;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CSP_SRC_RC,
    CSP_SRC_LFX,
    CSP_SRC_EXT
  } csp_src_t;

  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic flash;
  } csp_dom_en_t;

  typedef struct packed {
    logic [3:0] src_sel;
    logic [1:0] dly_sel;
    logic       div8_n;
    logic       clkout_n;
  } csp_fuse_t;

  // Period mask for a prescale code: factor minus one
  function automatic logic [7:0] csp_div_mask(input logic [3:0] code);
    logic [8:0] one_hot;
    one_hot = 9'h001 << code;
    return 8'(one_hot - 9'h001);
  endfunction : csp_div_mask

endpackage : csp_pkg

`default_nettype wire

// ===== csp_prescaler.sv
`default_nettype none

module csp_prescaler
  import csp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] sel_in,
  output var  logic       tick,
  output var  logic       level,
  output var  logic [3:0] sel_active
);

  // ---------------------------------------------------------------
  // Counter on the undivided clock
  // ---------------------------------------------------------------
  logic [7:0] cnt_reg;
  logic [3:0] sel_cur_reg;
  logic       tick_reg;
  logic       lvl_reg;

  wire  [7:0] cur_mask  = csp_div_mask(sel_cur_reg);
  // Period ends when all masked bits are set
  wire        at_end    = (cnt_reg & cur_mask) == cur_mask;
  // New factor only taken at a period boundary, so no short pulse
  wire        switch_now = at_end && (sel_in != sel_cur_reg);
  wire  [3:0] sel_next  = switch_now ? sel_in : sel_cur_reg;
  wire  [7:0] cnt_next  = at_end ? 8'h00 : 8'(cnt_reg + 8'h01);
  wire  [7:0] next_mask = csp_div_mask(sel_next);
  // High during first half of each divided period; code 0 toggles
  wire        lvl_next  = (sel_next == CSP_PS_DIV1) ? ~lvl_reg
                          : (cnt_next <= (next_mask >> 1));

  // Old period runs out (T1), then a full new period (T2)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg     <= 8'h00;
      sel_cur_reg <= CSP_PS_DIV1;
      tick_reg    <= 1'b0;
      lvl_reg     <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      sel_cur_reg <= sel_next;
      tick_reg    <= at_end;
      lvl_reg     <= lvl_next;
    end
  end

  assign tick       = tick_reg;
  assign level      = lvl_reg;
  assign sel_active = sel_cur_reg;

endmodule : csp_prescaler

`default_nettype wire

// ===== csp_clock_ctrl.sv
`default_nettype none

module csp_clock_ctrl
  import csp_pkg::*;
#(
  parameter logic [16:0] WDT_SHORT_CYC = 17'h0_1000,
  parameter logic [16:0] WDT_LONG_CYC  = 17'h1_0000,
  parameter logic [16:0] WAKE_32K_CK   = 17'h0_8000
) (
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // Avalon-MM slave
  input  wire logic [CSP_AW-1:0]    AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  output var  logic [31:0]          AVS_READDATA,
  output var  logic                 AVS_WAITREQUEST,
  // Fuses and pins
  input  wire csp_fuse_t            FUSES,
  input  wire logic [7:0]           TRIM_FACTORY,
  input  wire logic                 WDT_OSC,
  // Sleep control from the core
  input  wire logic                 SLEEP_REQ,
  input  wire logic                 WAKE_REQ,
  // Clock system outputs
  output var  csp_dom_en_t          CLK_EN,
  output var  logic                 CLKOUT_O,
  output var  logic                 CLKOUT_OE,
  output var  logic [1:0]           CLK_SRC,
  output var  logic                 CPU_RUN,
  output var  logic [7:0]           RC_TRIM,
  output var  logic                 TOSC_EN,
  output var  logic                 TOSC_EXT
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYW = $bits(csp_fuse_t) + 9;
  logic [SYW-1:0] sync1_reg;
  logic [SYW-1:0] sync2_reg;
  logic           wdt_prev_reg;

  // First stage read only by the second stage
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      wdt_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {FUSES, TRIM_FACTORY, WDT_OSC};
      sync2_reg    <= sync1_reg;
      wdt_prev_reg <= sync2_reg[0];
    end
  end

  csp_fuse_t  fuse_s;
  wire  [7:0] trim_s   = sync2_reg[8:1];
  // Watchdog oscillator rising edge
  wire        wdt_tick = sync2_reg[0] & ~wdt_prev_reg;
  assign fuse_s = csp_fuse_t'(sync2_reg[SYW-1:9]);

  // ---------------------------------------------------------------
  // Fuse decode
  // ---------------------------------------------------------------
  wire sel_lfx = (fuse_s.src_sel == CSP_SRCSEL_LFX_F)
              || (fuse_s.src_sel == CSP_SRCSEL_LFX_S);
  wire sel_ext = fuse_s.src_sel == CSP_SRCSEL_EXT;
  wire sel_rc  = fuse_s.src_sel == CSP_SRCSEL_RC;
  // Other codes are unsupported here and fall back to RC
  wire srcsel_bad = !(sel_lfx || sel_ext || sel_rc);
  wire dly_bad    = fuse_s.dly_sel == CSP_DLY_RSVD;
  wire [1:0] dly_eff = dly_bad ? CSP_DLY_LONG : fuse_s.dly_sel;
  csp_src_t src_dec;
  assign src_dec = sel_lfx ? CSP_SRC_LFX
                 : (sel_ext ? CSP_SRC_EXT : CSP_SRC_RC);

  // Wake-up length in source cycles
  wire [16:0] wake_dec =
      (fuse_s.src_sel == CSP_SRCSEL_LFX_F) ? CSP_WAKE_1K_CK
    : (fuse_s.src_sel == CSP_SRCSEL_LFX_S) ? WAKE_32K_CK
    : CSP_WAKE_RC_CK;

  // Prescale start value from the divide fuse (fuse low = programmed)
  wire [3:0] ps_init = fuse_s.div8_n ? CSP_PS_DIV1 : CSP_PS_DIV8;

  // ---------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FUSE,
    ST_DLY14,
    ST_WDT,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } csp_state_t;

  csp_state_t  state_reg;
  csp_state_t  state_next;
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  csp_src_t    src_reg;
  logic [1:0]  dly_reg;
  logic [16:0] wake_len_reg;
  logic        cfg_err_reg;
  logic        clkout_reg;

  wire fuse_done = cnt_reg == 17'(CSP_FUSE_SETTLE - 17'h0_0001);
  wire d14_done  = cnt_reg == 17'(CSP_RST_CK - 17'h0_0001);
  wire [16:0] wdt_len = (dly_reg == CSP_DLY_SHORT) ? WDT_SHORT_CYC
                                                   : WDT_LONG_CYC;
  wire wdt_done  = wdt_tick && (cnt_reg == 17'(wdt_len - 17'h0_0001));
  wire wake_done = cnt_reg == 17'(wake_len_reg - 17'h0_0001);
  wire in_boot   = (state_reg == ST_FUSE) || (state_reg == ST_DLY14)
                || (state_reg == ST_WDT);

  // Next state and delay counter
  always_comb begin
    state_next = state_reg;
    cnt_next   = 17'(cnt_reg + 17'h0_0001);
    case (state_reg)
      ST_FUSE: begin
        if (fuse_done) begin
          state_next = ST_DLY14;
          cnt_next   = '0;
        end
      end
      ST_DLY14: begin
        // 14 cycles always, then the real-time part if asked
        if (d14_done) begin
          state_next = (dly_reg == CSP_DLY_14CK) ? ST_RUN : ST_WDT;
          cnt_next   = '0;
        end
      end
      ST_WDT: begin
        // Counts watchdog oscillator edges only
        cnt_next = wdt_tick ? 17'(cnt_reg + 17'h0_0001) : cnt_reg;
        if (wdt_done) begin
          state_next = ST_RUN;
          cnt_next   = '0;
        end
      end
      ST_RUN: begin
        cnt_next = '0;
        if (SLEEP_REQ) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        cnt_next = '0;
        if (WAKE_REQ) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_next = ST_RUN;
          cnt_next   = '0;
        end
      end
      default: begin
        state_next = ST_FUSE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_FUSE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Fuse-derived settings captured once the synchronisers settle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      src_reg      <= CSP_SRC_RC;
      dly_reg      <= CSP_DLY_LONG;
      wake_len_reg <= CSP_WAKE_RC_CK;
      cfg_err_reg  <= 1'b0;
      clkout_reg   <= 1'b0;
    end else if (state_reg == ST_FUSE && fuse_done) begin
      src_reg      <= src_dec;
      dly_reg      <= dly_eff;
      wake_len_reg <= wake_dec;
      cfg_err_reg  <= srcsel_bad || dly_bad;
      clkout_reg   <= ~fuse_s.clkout_n;
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  trim_reg;
  logic [3:0]  ps_sel_reg;
  logic        pce_reg;
  logic [2:0]  pce_cnt_reg;
  logic        tosc_en_reg;
  logic        tosc_ext_reg;
  logic [3:0]  ps_active;
  logic        ps_tick;
  logic        ps_level;

  wire       req       = AVS_READ | AVS_WRITE;
  wire       wr_accept = AVS_WRITE && !wait_reg;
  wire [2:0] idx       = AVS_ADDRESS[CSP_AW-1:2];
  wire       wr_lo     = wr_accept && AVS_BYTEENABLE[0];
  wire [7:0] wd        = AVS_WRITEDATA[7:0];
  wire       wr_trim   = wr_lo && idx == CSP_IDX_TRIM;
  wire       wr_presc  = wr_lo && idx == CSP_IDX_PRESC;
  wire       wr_async  = wr_lo && idx == CSP_IDX_ASYNC;

  // Read mux; unmapped words read zero
  wire [7:0] status_byte = {ps_active, cfg_err_reg,
                            (state_reg == ST_RUN), src_reg};
  wire [7:0] rd_byte =
      (idx == CSP_IDX_TRIM)   ? trim_reg
    : (idx == CSP_IDX_PRESC)  ? {pce_reg, 3'h0, ps_sel_reg}
    : (idx == CSP_IDX_ASYNC)  ? {6'h00, tosc_ext_reg, tosc_en_reg}
    : (idx == CSP_IDX_STATUS) ? status_byte
    : 8'h00;

  // One wait cycle, then one cycle with waitrequest low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg  <= !(req && wait_reg);
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // Trim and timer oscillator control
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trim_reg     <= CSP_TRIM_RST;
      tosc_en_reg  <= 1'b0;
      tosc_ext_reg <= 1'b0;
    end else begin
      if (in_boot) begin
        trim_reg <= trim_s;
      end else if (wr_trim) begin
        trim_reg <= wd;
      end
      if (wr_async) begin
        tosc_en_reg  <= wd[CSP_TOSC_EN_BIT];
        tosc_ext_reg <= wd[CSP_TOSC_EXT_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescale register with timed change enable
  // ---------------------------------------------------------------
  wire pce_arm    = wr_presc && !pce_reg && (wd == CSP_PCE_ONLY);
  wire ps_commit  = wr_presc && pce_reg && !wd[CSP_PCE_BIT];
  // Reserved codes are dropped, the old factor stays
  wire ps_valid   = wd[3:0] <= CSP_PS_MAX;
  wire pce_expire = pce_reg && (pce_cnt_reg == 3'(CSP_PCE_WINDOW - 3'h1));

  // A rewrite of the enable alone neither extends nor clears it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ps_sel_reg  <= CSP_PS_DIV1;
      pce_reg     <= 1'b0;
      pce_cnt_reg <= '0;
    end else begin
      if (state_reg == ST_FUSE && fuse_done) begin
        ps_sel_reg <= ps_init;
      end else if (ps_commit && ps_valid) begin
        ps_sel_reg <= wd[3:0];
      end
      if (pce_arm) begin
        pce_reg     <= 1'b1;
        pce_cnt_reg <= '0;
      end else if (ps_commit || pce_expire) begin
        pce_reg     <= 1'b0;
      end else if (pce_reg) begin
        pce_cnt_reg <= 3'(pce_cnt_reg + 3'h1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Glitch-free divider
  // ---------------------------------------------------------------
  csp_prescaler u_presc (
    .clk        (CLK),
    .rst        (RST),
    .sel_in     (ps_sel_reg),
    .tick       (ps_tick),
    .level      (ps_level),
    .sel_active (ps_active)
  );

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // All four domains take the same enable; CPU halted outside run
  csp_dom_en_t en_next;
  wire         cpu_ok = state_next == ST_RUN;
  assign en_next.cpu   = ps_tick && cpu_ok;
  assign en_next.io    = ps_tick && cpu_ok;
  assign en_next.adc   = ps_tick && cpu_ok;
  assign en_next.flash = ps_tick && cpu_ok;

  // Timer oscillator shares crystal pins, so RC source only
  wire tosc_ok = src_reg == CSP_SRC_RC;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CLK_EN   <= '0;
      CLKOUT_O  <= 1'b0;
      CLKOUT_OE <= 1'b0;
      CLK_SRC  <= CSP_SRC_RC;
      CPU_RUN  <= 1'b0;
      RC_TRIM  <= CSP_TRIM_RST;
      TOSC_EN  <= 1'b0;
      TOSC_EXT <= 1'b0;
    end else begin
      CLK_EN   <= en_next;
      // Divided clock on the pin, also during boot delay
      CLKOUT_O  <= clkout_reg && ps_level;
      CLKOUT_OE <= clkout_reg;
      CLK_SRC  <= src_reg;
      CPU_RUN  <= cpu_ok;
      RC_TRIM  <= trim_reg;
      TOSC_EN  <= tosc_en_reg && tosc_ok;
      TOSC_EXT <= tosc_ext_reg && tosc_en_reg && tosc_ok;
    end
  end

  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA    = rdata_reg;

endmodule : csp_clock_ctrl

`default_nettype wire

// ===== csp_clock_ctrl_properties.sv
`default_nettype none

module csp_clock_ctrl_properties
  import csp_pkg::*;
#(
  parameter logic [16:0] WDT_SHORT_CYC = 17'h0_1000,
  parameter logic [16:0] WDT_LONG_CYC  = 17'h1_0000,
  parameter logic [16:0] WAKE_32K_CK   = 17'h0_8000
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire csp_fuse_t   FUSES,
  input wire csp_dom_en_t CLK_EN,
  input wire logic        CLKOUT_O,
  input wire logic        CLKOUT_OE,
  input wire logic [1:0]  CLK_SRC,
  input wire logic        CPU_RUN,
  input wire logic        TOSC_EN,
  input wire logic        TOSC_EXT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // --------
  // Helpers
  // --------
  // Source implied by the fuse code; reserved codes fall back to RC
  wire logic [1:0] src_exp = (FUSES.src_sel == CSP_SRCSEL_EXT) ? 2'h2 :
                             (FUSES.src_sel[3:1] == 3'h3) ? 2'h1 : 2'h0;
  logic [5:0]      boot_cnt;

  // Saturating age since reset, so wake-ups never look like boots
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) boot_cnt <= 6'h00;
    else if (boot_cnt != 6'h3F) boot_cnt <= boot_cnt + 6'h01;
  end

  // --------
  // Checks
  // --------
  bus_answer_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Bus request not answered after one wait cycle");
  bus_single_a: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("Waitrequest low for more than one cycle");
  dom_equal_a: assert property (
    CLK_EN.cpu == CLK_EN.io && CLK_EN.io == CLK_EN.adc &&
    CLK_EN.adc == CLK_EN.flash)
    else $error("Clock domains divided unequally");
  en_run_a: assert property (
    CLK_EN.cpu |-> CPU_RUN || $past(CPU_RUN))
    else $error("Clock enable pulse while stopped");
  oe_fuse_a: assert property (
    CPU_RUN |-> CLKOUT_OE == !FUSES.clkout_n)
    else $error("Clock output enable disagrees with fuse");
  clkout_gate_a: assert property (
    !CLKOUT_OE |-> !CLKOUT_O)
    else $error("Clock output active without enable");
  src_fuse_a: assert property (
    CPU_RUN |-> CLK_SRC == src_exp)
    else $error("Clock source disagrees with fuse code");
  tosc_rc_a: assert property (
    TOSC_EN |-> CLK_SRC == 2'h0)
    else $error("Timer oscillator on without RC source");
  tosc_ext_a: assert property (
    TOSC_EXT |-> TOSC_EN)
    else $error("Timer external input without timer oscillator");
  boot_delay_a: assert property (
    $rose(CPU_RUN) |-> boot_cnt >= 6'h0E)
    else $error("Run started before the reset delay");
endmodule : csp_clock_ctrl_properties

bind csp_clock_ctrl csp_clock_ctrl_properties #(
  .WDT_SHORT_CYC(WDT_SHORT_CYC), .WDT_LONG_CYC(WDT_LONG_CYC),
  .WAKE_32K_CK(WAKE_32K_CK)
) csp_clock_ctrl_properties_inst (
  .CLK(CLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .FUSES(FUSES), .CLK_EN(CLK_EN),
  .CLKOUT_O(CLKOUT_O), .CLKOUT_OE(CLKOUT_OE), .CLK_SRC(CLK_SRC),
  .CPU_RUN(CPU_RUN), .TOSC_EN(TOSC_EN), .TOSC_EXT(TOSC_EXT)
);

`default_nettype wire

// ===== csp_osc_model.sv
`default_nettype none

module csp_osc_model #(
  parameter int HALF_NS = 97
) (
  output var logic wdt_osc
);
  timeunit 1ns;
  timeprecision 1ns;

  // Free-running, phase unrelated to CLK; a fixed rate never jumps
  initial begin
    wdt_osc = 1'b0;
    forever #(HALF_NS) wdt_osc = ~wdt_osc;
  end
endmodule : csp_osc_model

`default_nettype wire

// ===== csp_clock_ctrl_bench.sv
`default_nettype none

module csp_clock_ctrl_bench
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              CLK = 1'b0;
  logic              RST = 1'b1;
  logic [CSP_AW-1:0] AVS_ADDRESS = '0;
  logic              AVS_READ = 1'b0;
  logic              AVS_WRITE = 1'b0;
  logic [31:0]       AVS_WRITEDATA = '0;
  logic [31:0]       AVS_READDATA;
  logic              AVS_WAITREQUEST;
  csp_fuse_t         FUSES = '0;
  logic              WDT_OSC;
  logic              SLEEP_REQ = 1'b0;
  logic              WAKE_REQ = 1'b0;
  csp_dom_en_t       CLK_EN;
  logic              CLKOUT_O, CLKOUT_OE, CPU_RUN, TOSC_EN, TOSC_EXT;
  logic [1:0]        CLK_SRC;
  logic [7:0]        RC_TRIM;
  logic [31:0]       rd;
  int                gap_n;
  int                fails = 0;
  int                n_compared = 0;
  // Fuse sets: RC div8, external, fast crystal, slow crystal, reserved
  logic [7:0]        cfg_tab [5] = '{8'h24, 8'h03, 8'h6A, 8'h73, 8'h3C};
  int                wake_tab [5] = '{6, 6, 1024, 16, 6};

  always #10 CLK = ~CLK;

  csp_osc_model csp_osc_model_inst (.wdt_osc(WDT_OSC));

  // Short watchdog counts keep the boot waits brief
  csp_clock_ctrl #(
    .WDT_SHORT_CYC(17'h0_0004), .WDT_LONG_CYC(17'h0_0008),
    .WAKE_32K_CK(17'h0_0010)
  ) csp_clock_ctrl_inst (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'hF),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .FUSES(FUSES),
    .TRIM_FACTORY(8'h5A), .WDT_OSC(WDT_OSC), .SLEEP_REQ(SLEEP_REQ),
    .WAKE_REQ(WAKE_REQ), .CLK_EN(CLK_EN), .CLKOUT_O(CLKOUT_O),
    .CLKOUT_OE(CLKOUT_OE), .CLK_SRC(CLK_SRC), .CPU_RUN(CPU_RUN),
    .RC_TRIM(RC_TRIM), .TOSC_EN(TOSC_EN), .TOSC_EXT(TOSC_EXT)
  );

  // --------
  // Helpers
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [CSP_AW-1:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    AVS_WRITEDATA <= {24'h00_0000, d};
    // No local limit: only the watchdog ends a hung access
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    chk(n, 32'h2);
  endtask : bus

  // Cycles between two enable pulses, a full divided period
  task automatic gap();
    int n;
    n = 0;
    do @(posedge CLK); while (CLK_EN.cpu !== 1'b1 && ++n < 600);
    gap_n = 0;
    do begin
      @(posedge CLK);
      gap_n++;
    end while (CLK_EN.cpu !== 1'b1 && gap_n < 600);
  endtask : gap

  // --------
  // Scenarios
  // --------
  // Boot with a fuse set, check start-up, pins, sleep and wake
  task automatic boot(input logic [7:0] f, input int wake);
    int   n;
    logic prev;
    logic rc;
    rc = (f[7:4] != 4'h0) && (f[7:5] != 3'h3); // Reserved codes run on RC
    @(posedge CLK);
    FUSES <= csp_fuse_t'(f);
    RST   <= 1'b1;
    repeat (10) @(posedge CLK);
    chk(32'(RC_TRIM), 32'h80);
    RST <= 1'b0;
    n = 0;
    while (CPU_RUN !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    chk(32'(f[3:2] == 2'h0 ? n inside {[14:22]} : n > 40), 32'h1);
    chk(32'(CLK_SRC), f[7:4] == 4'h0 ? 32'h2 : 32'(f[7:5] == 3'h3));
    chk(32'(CLKOUT_OE), 32'(!f[0]));
    chk(32'(RC_TRIM), 32'h5A);
    bus(1'b0, 5'h04, 8'h00);
    chk(rd, f[1] ? 32'h0 : 32'h3);
    bus(1'b0, 5'h0C, 8'h00);
    chk(32'(rd[3]), 32'(f[3:2] == 2'h3));
    bus(1'b1, 5'h08, 8'h03);
    repeat (2) @(posedge CLK);
    chk({TOSC_EN, TOSC_EXT}, {2{rc}});
    if (f[1:0] == 2'h0) begin
      gap();
      chk(gap_n, 32'h8);
      n = 0;
      repeat (160) begin
        prev = CLKOUT_O;
        @(posedge CLK);
        n += int'(CLKOUT_O && !prev);
      end
      chk(32'(n inside {[19:21]}), 32'h1);
    end
    SLEEP_REQ <= 1'b1;
    @(posedge CLK);
    SLEEP_REQ <= 1'b0;
    repeat (3) @(posedge CLK);
    WAKE_REQ <= 1'b1;
    @(posedge CLK);
    WAKE_REQ <= 1'b0;
    n = 0;
    while (CPU_RUN !== 1'b1 && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    chk(32'(n inside {[wake:wake + 3]}), 32'h1);
  endtask : boot

  // Every prescale code, then refused and late writes
  task automatic presc();
    int old;
    old = 8;
    for (int c = 0; c <= 8; c++) begin
      bus(1'b1, 5'h04, 8'h80);
      bus(1'b1, 5'h04, 8'(c));
      gap();
      chk(32'(gap_n >= (old < (1 << c) ? old : 1 << c)), 32'h1);
      gap();
      chk(gap_n, 32'(1 << c));
      old = 1 << c;
    end
    bus(1'b1, 5'h04, 8'h80);
    bus(1'b1, 5'h04, 8'h09);
    bus(1'b0, 5'h04, 8'h00);
    chk(rd, 32'h8);
    bus(1'b1, 5'h04, 8'h80);
    repeat (6) @(posedge CLK);
    bus(1'b1, 5'h04, 8'h02);
    bus(1'b0, 5'h04, 8'h00);
    chk(rd, 32'h8);
    // Re-arming inside the window must not stretch it
    bus(1'b1, 5'h04, 8'h80);
    bus(1'b1, 5'h04, 8'h80);
    bus(1'b1, 5'h04, 8'h01);
    bus(1'b0, 5'h04, 8'h00);
    chk(rd, 32'h8);
    bus(1'b0, 5'h10, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, 5'h00, 8'h33);
    bus(1'b0, 5'h00, 8'h00);
    chk(rd, 32'h33);
  endtask : presc

  task automatic test_done();
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    for (int i = 0; i < 5; i++) begin
      boot(cfg_tab[i], wake_tab[i]);
      if (i == 0) presc();
    end
    test_done();
  end

  // Whole run needs about 4k cycles; cut a hang at 50k
  initial begin
    #1_000_000;
    fails++;
    test_done();
  end
endmodule : csp_clock_ctrl_bench

`default_nettype wire
